/* File: rtl/pitq_pkg.sv */
// Constants and carrier types for the package query service
package pitq_pkg;
   // Clock and tick timing
   localparam int CLK_PERIOD_NS = 25;
   localparam int TICK_TIME_NS  = 1000000;
   localparam int TICK_CYCLES   = TICK_TIME_NS / CLK_PERIOD_NS;
   // Service indices
   localparam logic [7:0] IDX_IDENT  = 8'h00;
   localparam logic [7:0] IDX_PKGTMP = 8'h02;
   localparam logic [7:0] IDX_WAKE   = 8'h05;
   localparam logic [7:0] IDX_CORTMP = 8'h09;
   localparam logic [7:0] IDX_TTGT   = 8'h10;
   localparam logic [7:0] IDX_CAPLO  = 8'h1C;
   localparam logic [7:0] IDX_CAPHI  = 8'h1D;
   localparam logic [7:0] IDX_UNIT   = 8'h1E;
   localparam logic [7:0] IDX_RUNT   = 8'h1F;
   // Identification items
   localparam logic [15:0] ID_SIG   = 16'h0000;
   localparam logic [15:0] ID_PLAT  = 16'h0001;
   localparam logic [15:0] ID_DEV   = 16'h0002;
   localparam logic [15:0] ID_THR   = 16'h0003;
   localparam logic [15:0] ID_REV   = 16'h0004;
   localparam logic [15:0] ID_MCS   = 16'h0005;
   // Per-core parameter for system agent
   localparam logic [15:0] PRM_SA   = 16'h00FF;
   localparam int          NUM_CORES = 8;
   // Completion codes
   localparam logic [7:0] CC_OK      = 8'h40;
   localparam logic [7:0] CC_TIMEOUT = 8'h82;
   localparam logic [7:0] CC_BADPRM  = 8'h90;
   // Machine-check status bits
   localparam int MCS_MCE = 29;
   localparam int MCS_IE  = 30;
   localparam int MCS_CAT = 31;
   // Power-unit word reset value
   localparam logic [31:0] UNIT_RST = 32'h000A_1003;
   // Temperature-target fields
   localparam int TT_PROCHOT_LSB = 16;
   localparam int TT_CONTROL_LSB = 8;
   // Moving average fraction bits
   localparam int EMA_FRAC = 8;
   // Identity values, arbitrary
   localparam logic [31:0] ID_SIG_VAL = 32'h0001_2345;
   localparam logic [31:0] ID_DEV_VAL = 32'h0000_ABCD;
   localparam logic [31:0] ID_THR_VAL = 32'h0000_000F;
   localparam logic [31:0] ID_REV_VAL = 32'h0000_0101;
   localparam logic [2:0]  ID_PLAT_VAL = 3'h1;

   typedef struct packed {
      logic        write;
      logic [7:0]  index;
      logic [15:0] param;
      logic [31:0] wdata;
   } pitq_req_t;

   typedef struct packed {
      logic [7:0]  cc;
      logic [31:0] data;
   } pitq_rsp_t;
endpackage

/* File: rtl/pitq_top.sv */
// Package identification, power and thermal query service
`timescale 1ns/1ps

// Behaviour
// - Machine-check word sets bits 29, 30, 31 on those errors
// - Power-unit word resets to power 3, energy 16, time 10
// - 64-bit capability read as two 32-bit halves by index
// - Capability holds design power, minimum and maximum power
// - Longest sustainable time window sits in bits 54:48
// - Firmware loads capability once at boot, then read-only
// - Wake bit set and low power: config commands force C2
// - Wake bit clear and resources down: config commands raise cfg_timeout
// - Wake bit is writable and readable by the host
// - Run time is a 32-bit wrapping count of milliseconds
// - Run-time count starts when package reset releases
// - Package temperature in low 16 bits, upper half zero
// - Package temperature is a 255/256 moving average per ms
// - Core read returns chosen core or system-agent temperature
// - Core parameter out of range answers code 0x90
// - Core temperature is instantaneous, refreshed each ms
// - Target word: throttle 23:16, fan threshold 15:8
// - Thread count fixed by variant, not by enabled cores
// - Revision word combines microcode and firmware versions
// - Platform read returns a three-bit processor flag
module pitq_top #(
   parameter int TICK_CYCLES = pitq_pkg::TICK_CYCLES
) (
   // Clock and package reset
   input  wire logic                mclk,
   input  wire logic                rst_b,
   // Service request and answer
   input  wire logic                req_valid,
   input  wire pitq_pkg::pitq_req_t req,
   output logic                     rsp_valid,
   output pitq_pkg::pitq_rsp_t      rsp,
   // Firmware capability load
   input  wire logic                cap_load,
   input  wire logic [63:0]         cap_data,
   input  wire logic [7:0]          fw_rev,
   input  wire logic [7:0]          t_prochot,
   input  wire logic [7:0]          t_control,
   // Error reporting
   input  wire logic                machine_check_error,
   input  wire logic                internal_error,
   input  wire logic                catastrophic_error_n,
   // Sensors
   input  wire logic [pitq_pkg::NUM_CORES-1:0][15:0] core_temp,
   input  wire logic [15:0]         uncore_temp,
   input  wire logic [15:0]         sa_temp,
   // Config command power handling
   input  wire logic                cfg_req,
   input  wire logic                pkg_low_power,
   output logic                     popup_c2,
   output logic                     cfg_timeout
);

   localparam int TW = $clog2(TICK_CYCLES);
   localparam logic [TW-1:0] TICK_LAST = TW'(TICK_CYCLES - 1);

   // Signed compare, sensors may read below zero
   function automatic logic [15:0] smax(input logic [15:0] a,
                                        input logic [15:0] b);
      smax = ($signed(a) > $signed(b)) ? a : b;
   endfunction

   ////////////////////////////////////////////////////////////////////
   // Millisecond tick and run time
   logic [TW-1:0] tick_cnt_ff;
   logic [TW-1:0] nxt_tick_cnt;
   logic          tick;
   logic [31:0]   run_ff;
   logic [31:0]   nxt_run;

   always_comb begin
      tick = (tick_cnt_ff == TICK_LAST);
      nxt_tick_cnt = tick ? '0 : tick_cnt_ff + TW'(1);
      nxt_run = tick ? run_ff + 32'h0000_0001 : run_ff;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tick_cnt_ff <= '0;
         run_ff      <= '0;
      end else begin
         tick_cnt_ff <= nxt_tick_cnt;
         run_ff      <= nxt_run;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Sensor maximum, average and snapshot
   logic [15:0] max_chain [pitq_pkg::NUM_CORES+1];
   logic [15:0] hot_now;

   assign max_chain[0] = uncore_temp;
   genvar gi;
   generate
      for (gi = 0; gi < pitq_pkg::NUM_CORES; gi++) begin : g_max
         assign max_chain[gi+1] = smax(max_chain[gi], core_temp[gi]);
      end
   endgenerate
   assign hot_now = max_chain[pitq_pkg::NUM_CORES];

   // Average keeps eight fraction bits
   logic [23:0] avg_ff;
   logic [23:0] nxt_avg;
   logic [pitq_pkg::NUM_CORES-1:0][15:0] snap_ff;
   logic [pitq_pkg::NUM_CORES-1:0][15:0] nxt_snap;
   logic [15:0] sa_snap_ff;
   logic [15:0] nxt_sa_snap;

   always_comb begin
      nxt_avg     = avg_ff;
      nxt_snap    = snap_ff;
      nxt_sa_snap = sa_snap_ff;
      if (tick) begin
         nxt_avg = avg_ff - {{pitq_pkg::EMA_FRAC{avg_ff[23]}},
                   avg_ff[23:pitq_pkg::EMA_FRAC]}
                 + {{pitq_pkg::EMA_FRAC{hot_now[15]}}, hot_now};
         nxt_snap    = core_temp;
         nxt_sa_snap = sa_temp;
      end
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         avg_ff     <= '0;
         snap_ff    <= '0;
         sa_snap_ff <= '0;
      end else begin
         avg_ff     <= nxt_avg;
         snap_ff    <= nxt_snap;
         sa_snap_ff <= nxt_sa_snap;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Capability, wake bit and error status
   // Capability locks after the first load
   logic [63:0] cap_ff;
   logic [63:0] nxt_cap;
   logic        cap_lock_ff;
   logic        nxt_cap_lock;
   logic        wake_ff;
   logic        nxt_wake;
   logic [2:0]  err_ff;
   logic [2:0]  nxt_err;
   logic        wr_wake;

   always_comb begin
      nxt_cap      = cap_ff;
      nxt_cap_lock = cap_lock_ff;
      if (cap_load && !cap_lock_ff) begin
         nxt_cap      = cap_data;
         nxt_cap_lock = 1'b1;
      end
      wr_wake  = req_valid && req.write
              && req.index == pitq_pkg::IDX_WAKE;
      nxt_wake = wr_wake ? req.wdata[0] : wake_ff;
      nxt_err = err_ff | {!catastrophic_error_n, internal_error,
                          machine_check_error};
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         cap_ff      <= '0;
         cap_lock_ff <= 1'b0;
         wake_ff     <= 1'b0;
         err_ff      <= '0;
      end else begin
         cap_ff      <= nxt_cap;
         cap_lock_ff <= nxt_cap_lock;
         wake_ff     <= nxt_wake;
         err_ff      <= nxt_err;
      end
   end

   ////////////////////////////////////////////////////////////////////
   // Config command power handling
   logic popup_ff;
   logic nxt_popup;
   logic tmo_ff;
   logic nxt_tmo;

   always_comb begin
      nxt_popup = cfg_req && pkg_low_power && wake_ff;
      nxt_tmo   = cfg_req && pkg_low_power && !wake_ff;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         popup_ff <= 1'b0;
         tmo_ff   <= 1'b0;
      end else begin
         popup_ff <= nxt_popup;
         tmo_ff   <= nxt_tmo;
      end
   end

   assign popup_c2    = popup_ff;
   assign cfg_timeout = tmo_ff;

   ////////////////////////////////////////////////////////////////////
   // Request decode and answer
   pitq_pkg::pitq_rsp_t rsp_ff;
   pitq_pkg::pitq_rsp_t nxt_rsp;
   logic                rsp_v_ff;
   logic                nxt_rsp_v;
   logic [31:0]         mcs;
   logic [15:0]         cidx;

   always_comb begin
      mcs = '0;
      mcs[pitq_pkg::MCS_MCE] = err_ff[0];
      mcs[pitq_pkg::MCS_IE]  = err_ff[1];
      mcs[pitq_pkg::MCS_CAT] = err_ff[2];
      cidx = req.param;
      nxt_rsp.cc   = pitq_pkg::CC_OK;
      nxt_rsp.data = '0;
      unique case (req.index)
         pitq_pkg::IDX_IDENT: begin
            unique case (req.param)
               pitq_pkg::ID_SIG: nxt_rsp.data = pitq_pkg::ID_SIG_VAL;
               pitq_pkg::ID_PLAT:
                  nxt_rsp.data = {29'h0, pitq_pkg::ID_PLAT_VAL};
               pitq_pkg::ID_DEV: nxt_rsp.data = pitq_pkg::ID_DEV_VAL;
               pitq_pkg::ID_THR: nxt_rsp.data = pitq_pkg::ID_THR_VAL;
               pitq_pkg::ID_REV:
                  nxt_rsp.data = {pitq_pkg::ID_REV_VAL[31:8], fw_rev};
               pitq_pkg::ID_MCS: nxt_rsp.data = mcs;
               default: nxt_rsp.cc = pitq_pkg::CC_BADPRM;
            endcase
         end
         pitq_pkg::IDX_PKGTMP:
            nxt_rsp.data = {16'h0000, avg_ff[23:pitq_pkg::EMA_FRAC]};
         pitq_pkg::IDX_WAKE: nxt_rsp.data = {31'h0, wake_ff};
         pitq_pkg::IDX_CORTMP: begin
            if (cidx == pitq_pkg::PRM_SA)
               nxt_rsp.data = {16'h0000, sa_snap_ff};
            else if (cidx < 16'(pitq_pkg::NUM_CORES))
               nxt_rsp.data = {16'h0000,
                  snap_ff[cidx[$clog2(pitq_pkg::NUM_CORES)-1:0]]};
            else
               nxt_rsp.cc = pitq_pkg::CC_BADPRM;
         end
         pitq_pkg::IDX_TTGT: begin
            nxt_rsp.data[pitq_pkg::TT_PROCHOT_LSB +: 8] = t_prochot;
            nxt_rsp.data[pitq_pkg::TT_CONTROL_LSB +: 8] = t_control;
         end
         pitq_pkg::IDX_CAPLO: nxt_rsp.data = cap_ff[31:0];
         pitq_pkg::IDX_CAPHI: nxt_rsp.data = cap_ff[63:32];
         pitq_pkg::IDX_UNIT: nxt_rsp.data = pitq_pkg::UNIT_RST;
         pitq_pkg::IDX_RUNT: nxt_rsp.data = run_ff;
         default: nxt_rsp.cc = pitq_pkg::CC_BADPRM;
      endcase
      if (req.write && req.index != pitq_pkg::IDX_WAKE)
         nxt_rsp.cc = pitq_pkg::CC_BADPRM;
      if (req.write)
         nxt_rsp.data = '0;
      // Answer holds until the next request
      nxt_rsp_v = req_valid;
      if (!req_valid)
         nxt_rsp = rsp_ff;
   end

   always_ff @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         rsp_ff   <= '0;
         rsp_v_ff <= 1'b0;
      end else begin
         rsp_v_ff <= nxt_rsp_v;
         rsp_ff   <= nxt_rsp;
      end
   end

   assign rsp_valid = rsp_v_ff;
   assign rsp       = rsp_ff;

endmodule // pitq_top

/* File: dv/pitq_properties.sv */
// Port assertions for the package query service
`timescale 1ns/1ps
module pitq_checker (
   // Clock and reset
   input wire logic                mclk,
   input wire logic                rst_b,
   // Requests and answers
   input wire logic                req_valid,
   input wire pitq_pkg::pitq_req_t req,
   input wire logic                rsp_valid,
   input wire pitq_pkg::pitq_rsp_t rsp,
   // Levels
   input wire logic [7:0]          t_prochot,
   input wire logic [7:0]          t_control,
   input wire logic                machine_check_error,
   input wire logic                cfg_req,
   input wire logic                pkg_low_power,
   input wire logic                popup_c2,
   input wire logic                cfg_timeout
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!rst_b);
   wire       rq = req_valid && !req.write;
   wire [7:0] ix = req.index;
   chk_rsp_next: assert property (req_valid |=> rsp_valid)
      else $error("answer late");
   chk_rsp_cause: assert property (rsp_valid |-> $past(req_valid))
      else $error("answer unasked");
   chk_unit_word: assert property (
      rq && ix == 8'h1E |=> rsp.data == 32'h000A_1003)
      else $error("unit word");
   chk_core_range: assert property (
      rq && ix == 8'h09 && req.param > 16'h0007 && req.param != 16'h00FF
      |=> rsp.cc == 8'h90)
      else $error("core range");
   chk_pkg_upper: assert property (
      rq && ix == 8'h02 |=> rsp.data[31:16] == 16'h0000)
      else $error("temp upper half");
   chk_tgt_fields: assert property (
      rq && ix == 8'h10
      |=> rsp.data == {8'h00, $past(t_prochot), $past(t_control), 8'h00})
      else $error("target word");
   chk_mce_bit: assert property (
      rq && ix == 8'h00 && req.param == 16'h0005 && $past(machine_check_error)
      |=> rsp.data[29])
      else $error("check bit");
   chk_wake_force: assert property (
      cfg_req && pkg_low_power |=> popup_c2 != cfg_timeout)
      else $error("wake handling");
   chk_cfg_idle: assert property (
      !(cfg_req && pkg_low_power) |=> !popup_c2 && !cfg_timeout)
      else $error("wake idle");
   chk_write_refuse: assert property (
      req_valid && req.write && ix != 8'h05
      |=> rsp.cc == 8'h90 && rsp.data == 32'h0000_0000)
      else $error("write refused");
endmodule // pitq_checker

bind pitq_top pitq_checker chk_u (.mclk(mclk), .rst_b(rst_b),
   .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
   .t_prochot(t_prochot), .t_control(t_control),
   .machine_check_error(machine_check_error), .cfg_req(cfg_req),
   .pkg_low_power(pkg_low_power), .popup_c2(popup_c2),
   .cfg_timeout(cfg_timeout));

/* File: dv/pitq_host_model.sv */
// Host-side requester model for the package query service
`timescale 1ns/1ps
module pitq_host_model (
   // Bench command
   input wire logic                mclk,
   input wire logic                go,
   input wire pitq_pkg::pitq_req_t go_req,
   // Service link
   output logic                    req_valid,
   output pitq_pkg::pitq_req_t     req,
   input wire logic                rsp_valid,
   input wire pitq_pkg::pitq_rsp_t rsp,
   output logic                    done,
   output pitq_pkg::pitq_rsp_t     got
);
   initial begin
      req_valid = 1'b0;
      req = '0;
      done = 1'b0;
      got = '0;
   end
   always @(negedge mclk) begin
      req_valid <= go;
      req <= go ? go_req : ~req;
   end
   always @(posedge mclk) begin
      done <= rsp_valid;
      if (rsp_valid) got <= rsp;
   end
endmodule // pitq_host_model

/* File: dv/pitq_top_tb.sv */
// Self-checking bench for the package query service
`timescale 1ns/1ps
module pitq_top_tb;
   localparam int TK = 20;
   logic        mclk, rst_b, go, done, req_valid, rsp_valid;
   logic        cap_load, mce, ie, cat_n, cfg_req, low, popup, tmo;
   pitq_pkg::pitq_req_t go_req, req;
   pitq_pkg::pitq_rsp_t rsp, got;
   logic [63:0] cap_data, cap_x;
   logic [7:0]  fw_rev, t_hot, t_ctl, cc;
   logic [pitq_pkg::NUM_CORES-1:0][15:0] core_temp;
   logic [15:0] unc_t, sa_t;
   logic [31:0] r0, ex;
   realtime     t_go;
   int          n_errors, total_checks, i;
   int          tk_n;
   logic signed [23:0] ema_x, ema_at;

   initial mclk = 1'b0;
   always #12.5 mclk = ~mclk;

   pitq_host_model host_u (.mclk(mclk), .go(go), .go_req(go_req),
      .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
      .done(done), .got(got));
   pitq_top #(.TICK_CYCLES(TK)) dut_u (.mclk(mclk), .rst_b(rst_b),
      .req_valid(req_valid), .req(req), .rsp_valid(rsp_valid), .rsp(rsp),
      .cap_load(cap_load), .cap_data(cap_data), .fw_rev(fw_rev),
      .t_prochot(t_hot), .t_control(t_ctl), .machine_check_error(mce),
      .internal_error(ie), .catastrophic_error_n(cat_n),
      .core_temp(core_temp), .uncore_temp(unc_t), .sa_temp(sa_t),
      .cfg_req(cfg_req), .pkg_low_power(low), .popup_c2(popup),
      .cfg_timeout(tmo));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk_rsp(input logic [7:0] c, input logic [31:0] d);
      total_checks++;
      if (got !== {c, d}) begin
         n_errors++;
         $display("[ERR] %0t got=%h exp=%h", $time, got, {c, d});
      end
   endtask
   task automatic chk_pin(input logic g, input logic e);
      total_checks++;
      if (g !== e) begin
         n_errors++;
         $display("[ERR] %0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic io(input logic w, input logic [7:0] ix,
                     input logic [15:0] p, input logic [31:0] d);
      int k;
      @(posedge mclk);
      t_go = $realtime;
      go_req <= '{w, ix, p, d};
      go <= 1'b1;
      @(posedge mclk);
      go <= 1'b0;
      ema_at = ema_x;
      for (k = 0; k < 9 && done !== 1'b1; k++) begin
         @(posedge mclk);
         #1;
      end
      if (done !== 1'b1) n_errors++;
   endtask
   task automatic rd(input logic [7:0] ix, input logic [15:0] p,
      input logic [31:0] d, input logic [7:0] c = pitq_pkg::CC_OK);
      io(1'b0, ix, p, 32'h0000_0000);
      chk_rsp(c, d);
   endtask
   function automatic logic [31:0] id_x(input int k);
      case (k)
         0: return pitq_pkg::ID_SIG_VAL;
         1: return {29'h0000_0000, pitq_pkg::ID_PLAT_VAL};
         2: return pitq_pkg::ID_DEV_VAL;
         3: return pitq_pkg::ID_THR_VAL;
         default: return {pitq_pkg::ID_REV_VAL[31:8], fw_rev};
      endcase
   endfunction
   function automatic logic signed [23:0] hot_x();
      logic signed [15:0] m;
      m = unc_t;
      for (int j = 0; j < pitq_pkg::NUM_CORES; j++)
         if ($signed(core_temp[j]) > m) m = core_temp[j];
      return {{8{m[15]}}, m};
   endfunction
   // Average model: 255/256 old plus 1/256 hottest each tick
   always @(posedge mclk or negedge rst_b) begin
      if (!rst_b) begin
         tk_n  <= 0;
         ema_x <= '0;
      end else begin
         tk_n <= tk_n + 1;
         if ((tk_n + 1) % TK == 0)
            ema_x <= ema_x - (ema_x >>> 8) + hot_x();
      end
   end
   task automatic end_of_test;
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      #(4000 * 25);
      n_errors++;
      end_of_test();
   end
   initial begin
      {go, cap_load, mce, ie, cfg_req, low, rst_b} = '0;
      cat_n = 1'b1;
      {go_req, cap_data, core_temp} = '0;
      {fw_rev, t_hot, t_ctl, unc_t, sa_t} = '0;
      r0 = $urandom(9868);
      repeat (4) @(posedge mclk);
      @(negedge mclk) rst_b = 1'b1;
      rd(pitq_pkg::IDX_RUNT, 16'h0000, 32'h0000_0000);
      while ($realtime < t_go + (3 * TK - 1) * 25) @(posedge mclk);
      rd(pitq_pkg::IDX_RUNT, 16'h0000, 32'h0000_0003);
      @(negedge mclk);
      cap_x = {$urandom, $urandom};
      cap_data = cap_x;
      cap_load = 1'b1;
      @(negedge mclk) cap_data = ~cap_x;
      @(negedge mclk) cap_load = 1'b0;
      rd(pitq_pkg::IDX_CAPLO, 16'h0000, cap_x[31:0]);
      rd(pitq_pkg::IDX_CAPHI, 16'h0000, cap_x[63:32]);
      rd(pitq_pkg::IDX_UNIT, 16'h0000, 32'h000A_1003);
      ex = 32'h0000_0001 << got.data[19:16];
      chk_pin(ex == 32'h0000_0400, 1'b1);
      io(1'b1, pitq_pkg::IDX_UNIT, 16'h0000, $urandom);
      chk_rsp(pitq_pkg::CC_BADPRM, 32'h0000_0000);
      @(negedge mclk) {cfg_req, low} = 2'b11;
      repeat (2) @(posedge mclk);
      #1 chk_pin(tmo, 1'b1);
      io(1'b1, pitq_pkg::IDX_WAKE, 16'h0000, 32'h0000_0001);
      chk_rsp(pitq_pkg::CC_OK, 32'h0000_0000);
      rd(pitq_pkg::IDX_WAKE, 16'h0000, 32'h0000_0001);
      chk_pin(popup, 1'b1);
      chk_pin(tmo, 1'b0);
      @(negedge mclk);
      {cfg_req, low, mce, ie, cat_n} = 5'h06;
      fw_rev = 8'($urandom);
      rd(pitq_pkg::IDX_IDENT, pitq_pkg::ID_MCS, 32'hE000_0000);
      @(negedge mclk) {mce, ie, cat_n} = 3'h1;
      for (i = 0; i < 5; i++) begin
         rd(pitq_pkg::IDX_IDENT, 16'(i), id_x(i));
      end
      rd(pitq_pkg::IDX_IDENT, 16'h0006, 32'h0000_0000,
         pitq_pkg::CC_BADPRM);
      rd(8'h20, 16'h0000, 32'h0000_0000, pitq_pkg::CC_BADPRM);
      @(negedge mclk);
      t_hot = 8'($urandom);
      t_ctl = 8'($urandom);
      rd(pitq_pkg::IDX_TTGT, 16'h0000, {8'h00, t_hot, t_ctl, 8'h00});
      @(negedge mclk);
      for (i = 0; i < pitq_pkg::NUM_CORES; i++) core_temp[i] = 16'($urandom);
      sa_t = 16'($urandom);
      unc_t = 16'($urandom);
      repeat (2 * TK) @(posedge mclk);
      rd(pitq_pkg::IDX_CORTMP, pitq_pkg::PRM_SA, {16'h0000, sa_t});
      io(1'b0, pitq_pkg::IDX_PKGTMP, 16'h0000, 32'h0000_0000);
      chk_rsp(pitq_pkg::CC_OK, {16'h0000, ema_at[23:8]});
      for (i = 0; i < 14; i++) begin
         r0 = $urandom_range(9);
         cc = (r0 < 8) ? pitq_pkg::CC_OK : pitq_pkg::CC_BADPRM;
         ex = (r0 < 8) ? {16'h0000, core_temp[r0[2:0]]} : 32'h0000_0000;
         rd(pitq_pkg::IDX_CORTMP, r0[15:0], ex, cc);
      end
      end_of_test();
   end
endmodule // pitq_top_tb
